// File: include/cpw_consts.vh
// register offsets, field positions, mode code and reset values for the pwm block
// assumes inclusion by plain name from any design file
`ifndef CPW_CONSTS_VH
`define CPW_CONSTS_VH
`define CPW_OFF_MODULE_CTRL 8'h00
`define CPW_OFF_DUTY_LOW 8'h04
`define CPW_OFF_DUTY_HIGH 8'h08
`define CPW_OFF_PERIOD 8'h0c
`define CPW_OFF_TIMER_CTRL 8'h10
`define CPW_OFF_FLAGS 8'h14
`define CPW_OFF_MASK 8'h18
`define CPW_OFF_PIN_CTRL 8'h1c
`define CPW_OFF_COUNT 8'h20
`define CPW_CTRL_EN_BIT 7
`define CPW_CTRL_FMT_BIT 4
`define CPW_CTRL_MODE_LSB 0
`define CPW_MODE_PWM 4'hf
`define CPW_TCTRL_ON_BIT 7
`define CPW_TCTRL_PRESCALE_LSB 4
`define CPW_TCTRL_SRC_LSB 0
`define CPW_PIN_DIR_BIT 0
`define CPW_PIN_SRC_LSB 1
`define CPW_PIN_SRC_PWM 5'h01
`define CPW_RESET_BYTE 8'h00
`define CPW_RESET_PERIOD 8'hff
`define CPW_RESET_PIN 8'h01
`endif

// File: core/cpw_prescaler.v
// prescale divider: one-cycle enable every 2**sel src_tick pulses
// assumes src_tick is a same-clock enable pulse stream
`timescale 1ns/1ps
module cpw_prescaler #(
    parameter WIDTH = 7
) (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire src_tick,
    input wire [2:0] sel,
    output reg tick
);
    reg [WIDTH-1:0] cnt;
    wire [WIDTH-1:0] mask = ~({WIDTH{1'b1}} << sel);
    always @(posedge clk) begin
        if (!rst_n || !run) begin
            cnt <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (src_tick) begin
                if ((cnt & mask) == mask) begin
                    cnt <= {WIDTH{1'b0}};
                    tick <= 1'b1;
                end else begin
                    cnt <= cnt + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// File: core/cpw_pwm_top.v
// pwm capture/compare unit with its period timer and axi4-lite registers
// assumes one 100 MHz clock, synchronous active-low reset, single-beat axi-lite master
//
// Notes on behaviour
// - control value selects pwm mode
// - duty from two bytes, alignment selected
// - timer clock divided by selected prescale
// - timer counts only while on bit set
// - period match sets sticky flag
// - each unit selects its own timer
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "cpw_consts.vh"
module cpw_pwm_top (
    input wire clk,
    input wire rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [1:0] timer_src_tick,
    output reg pin_out,
    output reg pin_oe_n,
    output reg irq
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [7:0] module_control_register;
    reg [7:0] duty_low_byte;
    reg [7:0] duty_high_byte;
    reg [7:0] period_register;
    reg [7:0] period_timer_control;
    reg [7:0] pin_ctrl;
    reg [7:0] flag_mask;
    reg period_match_flag;
    reg [7:0] count;
    reg [1:0] count_frac;
    reg [9:0] duty_latched;
    reg [1:0] src_sync1;
    reg [1:0] src_sync2;

    wire pwm_mode = module_control_register[`CPW_CTRL_EN_BIT] &&
        (module_control_register[`CPW_CTRL_MODE_LSB+3:`CPW_CTRL_MODE_LSB] == `CPW_MODE_PWM);
    wire duty_alignment_select = module_control_register[`CPW_CTRL_FMT_BIT];
    wire timer_on = period_timer_control[`CPW_TCTRL_ON_BIT];
    wire [2:0] prescale_select =
        period_timer_control[`CPW_TCTRL_PRESCALE_LSB+2:`CPW_TCTRL_PRESCALE_LSB];
    wire [1:0] timer_select = period_timer_control[`CPW_TCTRL_SRC_LSB+1:`CPW_TCTRL_SRC_LSB];
    wire pin_direction_bit = pin_ctrl[`CPW_PIN_DIR_BIT];
    wire [4:0] pin_output_source_select = pin_ctrl[`CPW_PIN_SRC_LSB+4:`CPW_PIN_SRC_LSB];

    // ------------------------------------------------------------------
    // duty decode
    // ------------------------------------------------------------------
    // left aligned: high byte holds bits 9..2, low byte bits 7..6 hold 1..0
    function [9:0] duty_value;
        input fmt;
        input [7:0] hi;
        input [7:0] lo;
        begin
            if (fmt)
                duty_value = {hi[1:0], lo};
            else
                duty_value = {hi, lo[7:6]};
        end
    endfunction

    wire [9:0] duty_now = duty_value(duty_alignment_select, duty_high_byte, duty_low_byte);

    // ------------------------------------------------------------------
    // timer source and prescaler
    // ------------------------------------------------------------------
    // sources 0 and 1 are the system clock; 2 and 3 are external ticks, synchronised
    wire [3:0] src_vec = {src_sync2, 1'b1, 1'b1};
    wire base_tick = (timer_select == 2'h0) ? 1'b1 : src_vec[timer_select];
    wire pre_tick;

    cpw_prescaler #(
        .WIDTH(7)
    ) u_pre (
        .clk(clk),
        .rst_n(rst_n),
        .run(timer_on),
        .src_tick(base_tick),
        .sel(prescale_select),
        .tick(pre_tick)
    );

    // 10-bit pwm time base: 8-bit count plus two fraction bits per prescaled tick
    wire [9:0] time_base = {count, count_frac};
    wire at_period = (count == period_register) && (count_frac == 2'h3);

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [7:0] w_data;
    reg w_lane;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire flag_read = do_read && (s_axi_araddr == `CPW_OFF_FLAGS);
    wire wr_hit = (aw_addr == `CPW_OFF_MODULE_CTRL) || (aw_addr == `CPW_OFF_DUTY_LOW) ||
        (aw_addr == `CPW_OFF_DUTY_HIGH) || (aw_addr == `CPW_OFF_PERIOD) ||
        (aw_addr == `CPW_OFF_TIMER_CTRL) || (aw_addr == `CPW_OFF_MASK) ||
        (aw_addr == `CPW_OFF_PIN_CTRL) || (aw_addr == `CPW_OFF_FLAGS);
    reg [8:0] rd_word;
    always @* begin
        rd_word = 9'h000;
        case (s_axi_araddr)
            `CPW_OFF_MODULE_CTRL: rd_word = {1'b1, module_control_register};
            `CPW_OFF_DUTY_LOW: rd_word = {1'b1, duty_low_byte};
            `CPW_OFF_DUTY_HIGH: rd_word = {1'b1, duty_high_byte};
            `CPW_OFF_PERIOD: rd_word = {1'b1, period_register};
            `CPW_OFF_TIMER_CTRL: rd_word = {1'b1, period_timer_control};
            `CPW_OFF_FLAGS: rd_word = {1'b1, 7'h00, period_match_flag};
            `CPW_OFF_MASK: rd_word = {1'b1, flag_mask};
            `CPW_OFF_PIN_CTRL: rd_word = {1'b1, pin_ctrl};
            `CPW_OFF_COUNT: rd_word = {1'b1, count};
            default: rd_word = 9'h000;
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_lane <= 1'b0;
            module_control_register <= `CPW_RESET_BYTE;
            duty_low_byte <= `CPW_RESET_BYTE;
            duty_high_byte <= `CPW_RESET_BYTE;
            period_register <= `CPW_RESET_PERIOD;
            period_timer_control <= `CPW_RESET_BYTE;
            pin_ctrl <= `CPW_RESET_PIN;
            flag_mask <= `CPW_RESET_BYTE;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
                if (w_lane) begin
                    case (aw_addr)
                        `CPW_OFF_MODULE_CTRL: module_control_register <= w_data;
                        `CPW_OFF_DUTY_LOW: duty_low_byte <= w_data;
                        `CPW_OFF_DUTY_HIGH: duty_high_byte <= w_data;
                        `CPW_OFF_PERIOD: period_register <= w_data;
                        `CPW_OFF_TIMER_CTRL: period_timer_control <= w_data;
                        `CPW_OFF_MASK: flag_mask <= w_data;
                        `CPW_OFF_PIN_CTRL: pin_ctrl <= w_data;
                        default: pin_ctrl <= pin_ctrl;
                    endcase
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_word[7:0]};
                s_axi_rresp <= rd_word[8] ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // period timer, flag and pwm output
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            src_sync1 <= 2'h0;
            src_sync2 <= 2'h0;
            count <= 8'h00;
            count_frac <= 2'h0;
            duty_latched <= 10'h000;
            period_match_flag <= 1'b0;
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            irq <= 1'b0;
        end else begin
            src_sync1 <= timer_src_tick;
            src_sync2 <= src_sync1;
            if (timer_on && pre_tick) begin
                if (at_period) begin
                    count <= 8'h00;
                    count_frac <= 2'h0;
                    duty_latched <= duty_now;
                    if (pwm_mode)
                        pin_out <= (duty_now != 10'h000);
                end else begin
                    {count, count_frac} <= time_base + 10'h001;
                    if (pwm_mode && (time_base + 10'h001 == duty_latched))
                        pin_out <= 1'b0;
                end
            end
            if (!pwm_mode)
                pin_out <= 1'b0;
            // set beats a clearing read in the same cycle
            if (timer_on && pre_tick && at_period)
                period_match_flag <= 1'b1;
            else if (flag_read)
                period_match_flag <= 1'b0;
            pin_oe_n <= pin_direction_bit ||
                (pin_output_source_select != `CPW_PIN_SRC_PWM);
            irq <= period_match_flag && flag_mask[0];
        end
    end
endmodule

// File: bench/cpw_pwm_sva.sv
// checker for the pwm unit: bus answers, pin and interrupt timing
// assumes it is bound to cpw_pwm_top and sees only its ports
`timescale 1ns/1ps
module cpw_pwm_sva (
    input wire clk,
    input wire rst_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire pin_out,
    input wire pin_oe_n,
    input wire irq
);
    // ----------
    // helper state
    // ----------
    reg [3:0] since_acc;
    reg wrote;
    always @(posedge clk) begin
        if (!rst_n) begin
            since_acc <= 4'hf;
            wrote <= 1'b0;
        end else begin
            if ((s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready))
                since_acc <= 4'h0;
            else if (since_acc != 4'hf)
                since_acc <= since_acc + 4'h1;
            if (s_axi_bvalid)
                wrote <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence seq_wr_taken;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence seq_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_aw_single: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held past one cycle");
    a_wr_answer: assert property (seq_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (seq_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("second write response");
    a_pwm_needs_cfg: assert property ($rose(pin_out) |-> wrote)
        else $error("pin toggled before any setup");
    a_pwm_min_period: assert property ($rose(pin_out) |=> !$rose(pin_out) [*3])
        else $error("pwm period shorter than four ticks");
    a_oe_by_write: assert property ($fell(pin_oe_n) |-> since_acc <= 4'h6)
        else $error("driver enabled without a write");
    a_irq_clear: assert property ($fell(irq) |-> since_acc <= 4'h6)
        else $error("interrupt dropped without an access");
endmodule
bind cpw_pwm_top cpw_pwm_sva u_sva (.clk(clk), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));

// File: bench/cpw_pin_load.sv
// load on the pwm pin: measures high time and period between rises
// assumes a pull-down on the pin while its driver is off
`timescale 1ns/1ps
module cpw_pin_load (
    input wire clk,
    input wire pin_out,
    input wire pin_oe_n,
    output reg [15:0] hi_len,
    output reg [15:0] per_len,
    output reg [15:0] edges
);
    wire line = pin_oe_n ? 1'b0 : pin_out;
    reg last = 1'b0;
    reg [15:0] hc = 16'h0;
    reg [15:0] pc = 16'h0;
    initial begin
        hi_len = 16'h0;
        per_len = 16'h0;
        edges = 16'h0;
    end
    always @(posedge clk) begin
        last <= line;
        pc <= pc + 16'h1;
        hc <= hc + {15'h0, line};
        if (line && !last) begin
            per_len <= pc;
            hi_len <= hc;
            edges <= edges + 16'h1;
            pc <= 16'h1;
            hc <= 16'h1;
        end
    end
endmodule

// File: bench/tb.sv
// bench for the pwm unit: table of settings, then reset, error and irq cases
// assumes design, checker and pin load are compiled first
`timescale 1ns/1ps
`include "cpw_consts.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [7:0] awaddr = 8'h0, araddr = 8'h0;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg [1:0] tick = 2'b0;
    wire awready, wready, bvalid, arready, rvalid, pin_out, pin_oe_n, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] hi_len, per_len, edges;
    reg [31:0] rd;
    reg [1:0] rsp;
    reg [55:0] rows [0:4];
    reg [55:0] r;
    integer failures = 0, samples_checked = 0, i, n;
    always #5 clk = ~clk;
    cpw_pwm_top u_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_src_tick(tick), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .irq(irq));
    cpw_pin_load u_load (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .hi_len(hi_len), .per_len(per_len), .edges(edges));
    // ----------
    // bus tasks: ready is looked at on the falling edge, so no race with the design
    // ----------
    task wr(input [7:0] a, input [7:0] d);
        reg ha, hw;
        begin
            ha = 1'b0;
            hw = 1'b0;
            @(posedge clk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!(ha && hw)) begin
                @(negedge clk);
                ha = ha | (awready & awvalid);
                hw = hw | (wready & wvalid);
                @(posedge clk);
                if (ha) awvalid <= 1'b0;
                if (hw) wvalid <= 1'b0;
            end
            do @(negedge clk); while (bvalid !== 1'b1);
            rsp = bresp;
            @(posedge clk);
            bready <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do @(negedge clk); while (arready !== 1'b1);
            @(posedge clk);
            arvalid <= 1'b0;
            do @(negedge clk); while (rvalid !== 1'b1);
            rd = rdata;
            rsp = rresp;
            @(posedge clk);
            rready <= 1'b0;
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done;
    end
    // ----------
    // scenarios
    // ----------
    initial begin
        // ctrl, period, duty high, duty low, timer ctrl, high cycles, period cycles
        rows[0] = 56'h9f_09_00_0a_80_0a_28;
        rows[1] = 56'h8f_09_05_40_80_15_28;
        rows[2] = 56'h9f_09_00_14_90_28_50;
        rows[3] = 56'h9f_04_00_0a_a0_28_50;
        rows[4] = 56'h9f_09_00_0a_82_0a_28;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i++) begin
            r = rows[i];
            tick <= (i == 4) ? 2'b01 : 2'b00;
            wr(`CPW_OFF_TIMER_CTRL, 8'h00);
            wr(`CPW_OFF_PIN_CTRL, 8'h03);
            wr(`CPW_OFF_PERIOD, r[47:40]);
            wr(`CPW_OFF_MODULE_CTRL, r[55:48]);
            wr(`CPW_OFF_DUTY_HIGH, r[39:32]);
            wr(`CPW_OFF_DUTY_LOW, r[31:24]);
            rd_reg(`CPW_OFF_FLAGS);
            wr(`CPW_OFF_TIMER_CTRL, r[23:16]);
            do rd_reg(`CPW_OFF_FLAGS); while (rd[0] !== 1'b1);
            wr(`CPW_OFF_PIN_CTRL, 8'h02);
            n = edges;
            wait (edges == n + 3);
            `CHK(hi_len, {8'h0, r[15:8]})
            `CHK(per_len, {8'h0, r[7:0]})
        end
        rst_n <= 1'b0;
        tick <= 2'b00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK({pin_out, pin_oe_n, irq}, 3'b010)
        rd_reg(`CPW_OFF_PERIOD);
        `CHK(rd, 32'hff)
        rd_reg(`CPW_OFF_PIN_CTRL);
        `CHK(rd, 32'h1)
        rd_reg(`CPW_OFF_COUNT);
        `CHK(rd, 32'h0)
        rd_reg(8'h40);
        `CHK(rsp, 2'b10)
        wr(8'h44, 8'h01);
        `CHK(rsp, 2'b10)
        wr(`CPW_OFF_TIMER_CTRL, 8'h83);
        repeat (20) @(posedge clk);
        rd_reg(`CPW_OFF_COUNT);
        `CHK(rd, 32'h0)
        wr(`CPW_OFF_PERIOD, 8'h03);
        wr(`CPW_OFF_MASK, 8'h01);
        wr(`CPW_OFF_TIMER_CTRL, 8'h80);
        wait (irq === 1'b1);
        rd_reg(`CPW_OFF_FLAGS);
        `CHK(rd, 32'h1)
        wr(`CPW_OFF_MASK, 8'h00);
        wr(`CPW_OFF_MODULE_CTRL, 8'h80);
        wr(`CPW_OFF_PIN_CTRL, 8'h02);
        n = edges;
        repeat (100) @(posedge clk);
        `CHK(irq, 1'b0)
        `CHK(edges, n[15:0])
        test_done;
    end
endmodule
